/* File: bench/host_model.sv */
// Host side: pulses the init pin for a fixed count of clocks.
// Assumes the master clock keeps running through the pulse.
`timescale 1ns/100ps
`default_nettype none
module host_model #(parameter int HOLD = 12) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic start,
    output var  logic init_pin
);
    int cnt;
    // The block does not police the pulse length, so the host keeps it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            init_pin <= 1'h0;
        end else if (start && cnt == 0) begin
            cnt <= HOLD;
            init_pin <= 1'h1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            init_pin <= cnt > 1;
        end
    end
endmodule // host_model
`default_nettype wire

/* File: bench/sensor_ctrl_checker.sv */
// Port relations of the init and power mode block.
// Assumes one clock domain; bound to the block below.
`timescale 1ns/100ps
`default_nettype none
module sensor_ctrl_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       clock_enable,
    input wire logic       write_offset,
    input wire logic [5:0] offset_value,
    input wire logic       standby,
    input wire logic       state_reset,
    input wire logic [5:0] tristate,
    input wire logic [5:0] global_offset_adjust,
    input wire logic [8:0] positive_reference,
    input wire logic       offset_negative,
    input wire logic [4:0] offset_magnitude,
    input wire logic       register_access_ok,
    input wire logic       startup_busy,
    input wire logic       timing_run,
    input wire logic       analog_power_on,
    input wire logic       pixel_data_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_offset_split: assert property (
        {offset_negative, offset_magnitude} == global_offset_adjust)
        else $error("offset split wrong");
    a_write_taken: assert property (register_access_ok && clock_enable && write_offset
        |=> global_offset_adjust == $past(offset_value)) else $error("offset write lost");
    a_pos_ref_range: assert property (positive_reference <= 9'h0FA)
        else $error("positive reference out of range");
    a_startup_locked: assert property (startup_busy |-> !register_access_ok)
        else $error("access open in startup");
    a_write_refused: assert property (
        !register_access_ok && clock_enable && write_offset |=> global_offset_adjust == 6'h00)
        else $error("refused write landed");
    a_standby_power: assert property (standby |-> !timing_run && !analog_power_on)
        else $error("standby still running");
    a_reset_timing: assert property (state_reset |-> !timing_run)
        else $error("state reset still timing");
    a_reset_analog: assert property (state_reset && !standby |-> analog_power_on)
        else $error("state reset powered analog down");
    a_data_float: assert property (tristate[5] |-> pixel_data_oe_n)
        else $error("data bus driven while floated");
    cover property (standby);
    cover property (state_reset);
    cover property (!register_access_ok && write_offset);
endmodule // sensor_ctrl_checker
bind sensor_init_power_mode_control sensor_ctrl_checker u_chk (.clock, .rst, .clock_enable,
    .write_offset, .offset_value, .standby, .state_reset, .tristate, .global_offset_adjust,
    .positive_reference, .offset_negative, .offset_magnitude, .register_access_ok,
    .startup_busy, .timing_run, .analog_power_on, .pixel_data_oe_n);
`default_nettype wire

/* File: bench/test_sensor_init_power_mode_control.sv */
// Testbench: register writes by strobe, init pulses from the host model.
// Assumes the design's constants header.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_ctrl_defs.vh"
module test_sensor_init_power_mode_control;
    logic       clock;
    logic       rst;
    logic       start;
    logic       init_pin;
    logic [5:0] wsel;
    logic [8:0] wdata;
    wire  [5:0] oe_n;
    wire  [5:0] tri_q;
    wire  [5:0] ofs;
    wire  [8:0] pref;
    wire  [8:0] nref;
    wire  [4:0] mag;
    wire        sby, srst, neg, ok, run, ana;
    wire        busy, pv, fs, rs, cs, fl;
    wire  [9:0] pdata;
    int         n_mismatch;
    int         n_tests;
    int         i;
    sensor_init_power_mode_control u_sensor_init_power_mode_control (
        .clock(clock), .rst(rst), .clock_enable(1'h1), .init_pin(init_pin),
        .write_standby(wsel[0]), .standby_value(wdata[0]),
        .write_state_reset(wsel[1]), .state_reset_value(wdata[0]),
        .write_tristate(wsel[2]), .tristate_value(wdata[5:0]),
        .write_offset(wsel[3]), .offset_value(wdata[5:0]),
        .write_pos_ref(wsel[4]), .pos_ref_value(wdata),
        .write_neg_ref(wsel[5]), .neg_ref_value(wdata),
        .converter_code(10'h155), .standby(sby), .state_reset(srst), .tristate(tri_q),
        .global_offset_adjust(ofs), .positive_reference(pref), .negative_reference(nref),
        .offset_negative(neg), .offset_magnitude(mag), .register_access_ok(ok),
        .startup_busy(busy), .timing_run(run), .analog_power_on(ana), .pixel_valid(pv),
        .pixel_valid_oe_n(oe_n[0]), .frame_start(fs), .frame_start_oe_n(oe_n[1]),
        .row_readout_start(rs), .row_readout_start_oe_n(oe_n[2]), .capture_start(cs),
        .capture_start_oe_n(oe_n[3]), .flash_trigger(fl), .flash_trigger_oe_n(oe_n[4]),
        .pixel_data(pdata), .pixel_data_oe_n(oe_n[5]));
    host_model #(.HOLD(12)) u_host_model (.clock(clock), .rst(rst), .start(start),
        .init_pin(init_pin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int sel, input logic [8:0] v);
        @(posedge clock);
        wsel <= 6'h01 << sel;
        wdata <= v;
        @(posedge clock);
        wsel <= 6'h00;
        #1;
    endtask
    task automatic end_sim;
        $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait for register access to open
    task automatic wait_ok;
        int k;
        for (k = 0; k < 60 && ok !== 1'h1; k++) begin
            @(posedge clock);
            #1;
        end
        if (ok !== 1'h1) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        rst = 1'h1;
        start = 1'h0;
        wsel = 6'h00;
        wdata = 9'h000;
        n_mismatch = 0;
        n_tests = 0;
        repeat (3) @(posedge clock);
        #1;
        chk(oe_n, 9'h03F);
        chk(busy, 9'h001);
        chk(pref, `POS_REF_RESET);
        chk(nref, `NEG_REF_RESET);
        @(posedge clock);
        rst <= 1'h0;
        wait_ok();
        wr(3, 9'h025);
        chk({neg, mag}, 9'h025);
        wr(3, 9'h00A);
        chk({neg, mag}, 9'h00A);
        wr(4, 9'h1FF);
        chk(pref, 9'h0FA);
        wr(4, 9'h000);
        chk(pref, 9'h000);
        wr(5, 9'h0FA);
        chk(nref, 9'h0FA);
        for (i = 0; i < 6; i++) begin
            wr(2, 9'h001 << i);
            chk(oe_n, 9'h001 << i);
        end
        wr(2, 9'h000);
        chk(oe_n, 9'h000);
        wr(0, 9'h001);
        chk({run, ana}, 9'h000);
        wr(3, 9'h011);
        chk(ofs, 9'h011);
        wr(0, 9'h000);
        chk({run, ana}, 9'h003);
        wr(1, 9'h001);
        chk({run, ana}, 9'h001);
        wr(3, 9'h012);
        chk(ofs, 9'h012);
        wr(1, 9'h000);
        chk({run, ana, pref}, 11'h600);
        @(posedge clock);
        #1;
        chk({fs, rs, cs, fl, pv}, 9'h01D);
        chk(pdata, 10'h155);
        wr(0, 9'h001);
        wr(0, 9'h000);
        chk(pv, 9'h000);
        @(posedge clock);
        #1;
        chk({fs, pv}, 9'h001);
        wr(0, 9'h001);
        wr(1, 9'h001);
        @(posedge clock);
        start <= 1'h1;
        @(posedge clock);
        start <= 1'h0;
        repeat (9) @(posedge clock);
        #1;
        chk(oe_n, 9'h03F);
        chk({sby, srst, run, ana}, 9'h000);
        chk(pref, `POS_REF_RESET);
        chk(nref, `NEG_REF_RESET);
        wr(3, 9'h015);
        chk({ok, ofs}, 9'h000);
        wait_ok();
        chk({run, ana, oe_n}, 9'h0C0);
        chk(busy, 9'h000);
        wr(3, 9'h021);
        chk(ofs, 9'h021);
        end_sim();
    end
endmodule // test_sensor_init_power_mode_control
`default_nettype wire

/* File: rtl/pin_sync.v */
// Three-stage input synchroniser for pins from outside the clock domain.
// Output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input  wire clock,
    input  wire rst,
    input  wire enable,
    input  wire pin,
    output reg  level
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else if (enable) begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule // pin_sync

`default_nettype wire

/* File: rtl/sensor_ctrl_defs.vh */
// Constants for the sensor initialisation and power mode controller.
// Included by the design files; holds definitions only.
`ifndef SENSOR_CTRL_DEFS_VH
`define SENSOR_CTRL_DEFS_VH

// Power configuration register: standby bit
`define PWR_STANDBY_BIT        0
// Reset control register: state reset bit
`define RST_STATE_RESET_BIT    1
// Tristate control register bit positions
`define TRI_PIXEL_VALID_BIT    0
`define TRI_FRAME_START_BIT    1
`define TRI_ROW_START_BIT      2
`define TRI_CAPTURE_START_BIT  3
`define TRI_FLASH_BIT          4
`define TRI_DATA_BIT           5
`define TRI_WIDTH              6
// Offset code: sign bit plus magnitude
`define OFFSET_WIDTH           6
`define OFFSET_SIGN_BIT        5
`define OFFSET_RESET           6'h00
// References: code steps of 5 mV
`define REF_WIDTH              9
`define REF_STEP_UV            5000
// Positive reference 2.5 V down to 1.25 V: code = (2.5 V - Vp) / 5 mV
`define POS_REF_MAX_CODE       9'h0FA
// Negative reference 0 V up to 1.25 V: code = Vm / 5 mV
`define NEG_REF_MAX_CODE       9'h0FA
// Defaults: 1.9 V positive (code 120), 0.6 V negative (code 120)
`define POS_REF_RESET          9'h078
`define NEG_REF_RESET          9'h078
`define SAMPLE_WIDTH           10
// Frame timing (fixed values of 1280 columns by 1024 rows standing for the readout timing)
`define COL_WIDTH              11
`define ROW_WIDTH              11
`define COLS_PER_ROW           11'h500
`define ROWS_PER_FRAME         11'h400
// Least init pulse, in master clock cycles
`define INIT_MIN_CYCLES        4'h8
`define STARTUP_CYCLES         4'h4

`endif

/* File: rtl/sensor_init_power_mode_control.v */
// Initialisation, standby, state reset and tristate control of the sensor,
// plus the offset and reference settings of the final signal chain.
// Assumes one master clock; register writes arrive as strobes from the
// serial register decoder on the same clock.
//
// Function
// - The offset is a 6-bit sign-magnitude code applied ahead of conversion.
// - Reference codes set positive 2.5V..1.25V and negative 0V..1.25V in 5mV steps.
// - After initialisation the references default to 1.9V and 0.6V.
// - Each sample is delivered as a 10-bit code spanning the two references.
// - The init input is active high; high initialises, low resumes operation.
// - Startup loads defaults, clears counters and latches, sets up the analog chain.
// - While init is high the device sits in power saving with timing stopped.
// - During init outputs float, registers hold defaults and writes are refused.
// - Releasing init restarts at the first frame.
// - Standby bit stops timing and analog, keeps registers, resumes the frame on clear.
// - State reset bit stops timing, keeps analog, restarts the first frame on clear.
// - The tristate register can float each sync output and the pixel bus.
`timescale 1ns/100ps
`default_nettype none
`include "sensor_ctrl_defs.vh"

module sensor_init_power_mode_control (
    input  wire        clock,
    input  wire        rst,
    input  wire        clock_enable,
    input  wire        init_pin,
    input  wire        write_standby,
    input  wire        standby_value,
    input  wire        write_state_reset,
    input  wire        state_reset_value,
    input  wire        write_tristate,
    input  wire [5:0]  tristate_value,
    input  wire        write_offset,
    input  wire [5:0]  offset_value,
    input  wire        write_pos_ref,
    input  wire [8:0]  pos_ref_value,
    input  wire        write_neg_ref,
    input  wire [8:0]  neg_ref_value,
    input  wire [9:0]  converter_code,
    output reg         standby,
    output reg         state_reset,
    output reg  [5:0]  tristate,
    output reg  [5:0]  global_offset_adjust,
    output reg  [8:0]  positive_reference,
    output reg  [8:0]  negative_reference,
    output wire        offset_negative,
    output wire [4:0]  offset_magnitude,
    output wire        register_access_ok,
    output wire        startup_busy,
    output wire        timing_run,
    output wire        analog_power_on,
    output reg         pixel_valid,
    output wire        pixel_valid_oe_n,
    output reg         frame_start,
    output wire        frame_start_oe_n,
    output reg         row_readout_start,
    output wire        row_readout_start_oe_n,
    output reg         capture_start,
    output wire        capture_start_oe_n,
    output reg         flash_trigger,
    output wire        flash_trigger_oe_n,
    output reg  [9:0]  pixel_data,
    output wire        pixel_data_oe_n
);

    localparam ST_INIT    = 3'b001;
    localparam ST_STARTUP = 3'b010;
    localparam ST_RUN     = 3'b100;

    wire        init_level;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [3:0]  startup_count;
    reg  [10:0] col;
    reg  [10:0] row;
    reg  [9:0]  sample;

    ////////////////////////////////////////////////////////////////////////
    pin_sync init_sync (
        .clock  (clock),
        .rst    (rst),
        .enable (clock_enable),
        .pin    (init_pin),
        .level  (init_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Init sequence
    always @* begin
        case (state)
            ST_INIT:    next_state = init_level ? ST_INIT : ST_STARTUP;
            ST_STARTUP: next_state = init_level ? ST_INIT :
                        (startup_count == `STARTUP_CYCLES) ? ST_RUN : ST_STARTUP;
            ST_RUN:     next_state = init_level ? ST_INIT : ST_RUN;
            default:    next_state = ST_INIT;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state         <= ST_INIT;
            startup_count <= 4'h0;
        end else if (clock_enable) begin
            state <= next_state;
            if (state == ST_STARTUP) begin
                startup_count <= startup_count + 4'h1;
            end else begin
                startup_count <= 4'h0;
            end
        end
    end

    assign startup_busy       = (state != ST_RUN);
    // Writes are taken only once startup is over, never during init
    assign register_access_ok = (state == ST_RUN);
    assign timing_run         = (state == ST_RUN) && !standby && !state_reset;
    assign analog_power_on    = (state != ST_INIT) && !standby;

    ////////////////////////////////////////////////////////////////////////
    // Programming registers; init holds them at defaults
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            standby              <= 1'b0;
            state_reset          <= 1'b0;
            tristate             <= 6'h00;
            global_offset_adjust <= `OFFSET_RESET;
            positive_reference   <= `POS_REF_RESET;
            negative_reference   <= `NEG_REF_RESET;
        end else if (clock_enable) begin
            if (state != ST_RUN) begin
                standby              <= 1'b0;
                state_reset          <= 1'b0;
                tristate             <= 6'h00;
                global_offset_adjust <= `OFFSET_RESET;
                positive_reference   <= `POS_REF_RESET;
                negative_reference   <= `NEG_REF_RESET;
            end else begin
                // Init wins over a mode write in the same cycle, so neither mode
                // bit is still set once the state machine has dropped to init
                if (init_level) begin
                    standby     <= 1'b0;
                    state_reset <= 1'b0;
                end else begin
                    if (write_standby) standby <= standby_value;
                    if (write_state_reset) state_reset <= state_reset_value;
                end
                if (write_tristate) tristate <= tristate_value;
                if (write_offset) global_offset_adjust <= offset_value;
                // Out-of-range codes saturate at the 1.25 V limit
                if (write_pos_ref) begin
                    positive_reference <= (pos_ref_value > `POS_REF_MAX_CODE) ?
                                          `POS_REF_MAX_CODE : pos_ref_value;
                end
                if (write_neg_ref) begin
                    negative_reference <= (neg_ref_value > `NEG_REF_MAX_CODE) ?
                                          `NEG_REF_MAX_CODE : neg_ref_value;
                end
            end
        end
    end

    assign offset_negative  = global_offset_adjust[`OFFSET_SIGN_BIT];
    assign offset_magnitude = global_offset_adjust[4:0];

    ////////////////////////////////////////////////////////////////////////
    // Frame timing: standby freezes counters in place, state reset and
    // init return them to the first frame
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            col               <= 11'h000;
            row               <= 11'h000;
            sample            <= 10'h000;
            pixel_valid       <= 1'b0;
            frame_start       <= 1'b0;
            row_readout_start <= 1'b0;
            capture_start     <= 1'b0;
            flash_trigger     <= 1'b0;
            pixel_data        <= 10'h000;
        end else if (clock_enable) begin
            sample <= converter_code;
            if (state != ST_RUN || state_reset) begin
                col               <= 11'h000;
                row               <= 11'h000;
                pixel_valid       <= 1'b0;
                frame_start       <= 1'b0;
                row_readout_start <= 1'b0;
                capture_start     <= 1'b0;
                flash_trigger     <= 1'b0;
            end else if (!standby) begin
                frame_start       <= (col == 11'h000) && (row == 11'h000);
                row_readout_start <= (col == 11'h000);
                capture_start     <= (col == 11'h000) && (row == 11'h000);
                flash_trigger     <= (col == 11'h000) &&
                                     (row == `ROWS_PER_FRAME - 11'h002);
                pixel_valid       <= 1'b1;
                pixel_data        <= sample;
                if (col == `COLS_PER_ROW - 11'h001) begin
                    col <= 11'h000;
                    row <= (row == `ROWS_PER_FRAME - 11'h001) ? 11'h000 : row + 11'h001;
                end else begin
                    col <= col + 11'h001;
                end
            end else begin
                pixel_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output enables, low while driving
    wire float_all = (state == ST_INIT);
    assign pixel_valid_oe_n       = float_all | tristate[`TRI_PIXEL_VALID_BIT];
    assign frame_start_oe_n       = float_all | tristate[`TRI_FRAME_START_BIT];
    assign row_readout_start_oe_n = float_all | tristate[`TRI_ROW_START_BIT];
    assign capture_start_oe_n     = float_all | tristate[`TRI_CAPTURE_START_BIT];
    assign flash_trigger_oe_n     = float_all | tristate[`TRI_FLASH_BIT];
    assign pixel_data_oe_n        = float_all | tristate[`TRI_DATA_BIT];

endmodule // sensor_init_power_mode_control

`default_nettype wire
